// file: src/swc_top.sv
// sleep and wake controller: power states, sleep entry, wake sources
// assumes firmware on the register port, events synchronous to mclk_in
// Behaviour
// - two sleep states, sleep and deep sleep, with different wake sources
// - asleep: rtc runs, cpu and memories stop, lcd and meter keep going
// - sleep wakes on io, rtc, energy pulse or power recovery; reset default
// - deep sleep wakes only on io or power recovery; reset by default
// - wake_no_reset set: wake resumes without reset
// - resume clears pll lock, osc force and both sleep code bits
// - enabled wake pin wakes on either edge stable over 4 osc cycles
// - port0 pins wake only when port0_wake_enable is set
// - io wake sets io_wake_flag and detect bits, pins 0 and 1 sharing one bit
// - rtc flag plus pulse flag means pulse wake; rtc alone means rtc
// - sleep code 01 and 11 mean sleep, 10 means deep sleep
// - with pll, meter may sleep too or accumulate a constant
// - pll may keep running with only the mcu asleep
// - quick method reaches sleep only and always stops the pll
// - after reset osc state: regulator on, osc clocks mcu, mcu runs
// - mcu clock select 0 osc, 1 pll; read returns source in use
`timescale 1ns/100ps
module swc_top #(
   parameter int STABLE = swc_pkg::WAKE_STABLE_CYCLES
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire swc_pkg::swc_bus_req_t bus_in,
   output logic [7:0] rdata_out,
   input wire logic [3:0] wake_pin_in,
   input wire logic [3:0] wake_pin_enable_in,
   input wire swc_pkg::swc_events_t events_in,
   input wire logic power_good_in,
   input wire logic pll_locked_in,
   output logic [1:0] power_state_out,
   output logic mcu_clock_enable_out,
   output logic mcu_clock_pll_out,
   output logic pll_enable_out,
   output logic meter_clock_enable_out,
   output logic lcd_clock_enable_out,
   output logic rtc_enable_out,
   output logic regulator_enable_out,
   output logic system_reset_out
);
   swc_pkg::swc_state_t state;
   logic [7:0] csc;
   logic [7:0] wctl;
   logic [3:0] detect;
   logic io_flag;
   logic rtc_flag;
   logic pg_sync_a;
   logic pg_sync_b;
   logic [3:0] pin_edge;
   logic [3:0] pin_armed;
   logic [2:0] pin_hit;
   logic io_wake;
   logic sleep_req;
   logic [1:0] code;
   logic asleep;
   logic wake_now;
   logic rtc_wake;
   logic pulse_wake;
   logic do_reset;
   logic reset_pulse;
   logic wr_csc;
   logic [7:0] next_csc;
   logic mcu_src;

   // power good comes from the analog supervisor, so synchronise it
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pg_sync_a <= 1'b0;
         pg_sync_b <= 1'b0;
      end else begin
         pg_sync_a <= power_good_in;
         pg_sync_b <= pg_sync_a;
      end
   end

   // one filter per wake pin
   genvar gi;
   generate
      for (gi = 0; gi < swc_pkg::NUM_WAKE_PINS; gi++) begin : g_pin
         swc_pin_filter #(.STABLE(STABLE)) u_filt (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .pin_in(wake_pin_in[gi]),
            .edge_out(pin_edge[gi])
         );
      end
   endgenerate

   // pins 2 and 3 are the port0 pins, gated by port0_wake_enable
   always_comb begin
      pin_armed = wake_pin_enable_in;
      if (!wctl[swc_pkg::WC_PORT0]) begin
         pin_armed[2] = 1'b0;
         pin_armed[3] = 1'b0;
      end
   end
   assign pin_hit = {pin_edge[3] & pin_armed[3], pin_edge[2] & pin_armed[2],
                     (pin_edge[1] & pin_armed[1]) | (pin_edge[0] & pin_armed[0])};
   assign io_wake = |pin_hit;

   assign asleep = (state == swc_pkg::SWC_SLEEP) || (state == swc_pkg::SWC_DEEP);
   // only sleep honours rtc and pulse; deep sleep ignores them
   assign rtc_wake = (state == swc_pkg::SWC_SLEEP) && events_in.rtc;
   assign pulse_wake = (state == swc_pkg::SWC_SLEEP) && events_in.pulse;
   assign wake_now = asleep && (io_wake || events_in.power_recover || rtc_wake || pulse_wake);
   assign do_reset = wake_now && !wctl[swc_pkg::WC_NO_RESET];

   // decode sleep request from the new control byte
   assign wr_csc = bus_in.wr && (bus_in.addr == swc_pkg::ADDR_CLOCK_SLEEP_CONTROL);
   assign code = {bus_in.wdata[swc_pkg::CS_SLEEP_HIGH], bus_in.wdata[swc_pkg::CS_SLEEP_LOW]};
   // osc force enters sleep by itself (quick method), even from the pll, since
   // it moves the source to osc on its own; it never reaches deep sleep
   // a plain sleep code needs the osc source written in the same byte
   assign sleep_req = wr_csc && !pg_sync_b &&
                      (bus_in.wdata[swc_pkg::CS_OSC_FORCE] ||
                       (!bus_in.wdata[swc_pkg::CS_MCU_SEL] && (code != swc_pkg::CODE_NONE)));

   // power state machine; firmware writes enter sleep, wake events and pll lock move the rest
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= swc_pkg::SWC_OSC;
      end else begin
         case (state)
            swc_pkg::SWC_OSC, swc_pkg::SWC_WORK: begin
               if (sleep_req) begin
                  if (code == swc_pkg::CODE_DEEP && !bus_in.wdata[swc_pkg::CS_OSC_FORCE]) begin
                     state <= swc_pkg::SWC_DEEP;
                  end else begin
                     state <= swc_pkg::SWC_SLEEP;
                  end
               end else if (mcu_src) begin
                  state <= swc_pkg::SWC_WORK;
               end else begin
                  state <= swc_pkg::SWC_OSC;
               end
            end
            default: begin
               if (do_reset) begin
                  state <= swc_pkg::SWC_OSC;
               end else if (wake_now) begin
                  // resume: to work if mcu_src selects the locked pll, otherwise osc
                  state <= mcu_src ? swc_pkg::SWC_WORK : swc_pkg::SWC_OSC;
               end
            end
         endcase
      end
   end

   // mcu source in use; pll only once locked
   assign mcu_src = csc[swc_pkg::CS_MCU_SEL] && pll_locked_in;

   // control byte: write, osc force side effects, resume clear
   always_comb begin
      next_csc = csc;
      if (wr_csc) begin
         next_csc = bus_in.wdata;
         if (bus_in.wdata[swc_pkg::CS_OSC_FORCE]) begin
            next_csc[swc_pkg::CS_MCU_SEL] = 1'b0; // quick sleep drops the pll
            next_csc[swc_pkg::CS_PLL_LOCK] = 1'b0;
         end
      end
      if (wake_now && !do_reset) begin
         next_csc[swc_pkg::CS_PLL_LOCK] = 1'b0;
         next_csc[swc_pkg::CS_OSC_FORCE] = 1'b0;
         next_csc[swc_pkg::CS_SLEEP_HIGH] = 1'b0;
         next_csc[swc_pkg::CS_SLEEP_LOW] = 1'b0;
      end
   end

   // reset-wake restores defaults, like a system reset
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         csc <= swc_pkg::RST_CLOCK_SLEEP_CONTROL;
      end else if (do_reset) begin
         csc <= swc_pkg::RST_CLOCK_SLEEP_CONTROL;
      end else begin
         csc <= next_csc;
      end
   end

   // wake control survives reset-wakes so the policy holds
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wctl <= swc_pkg::RST_WAKE_CONTROL;
      end else if (bus_in.wr && bus_in.addr == swc_pkg::ADDR_WAKE_CONTROL) begin
         wctl <= {6'h00, bus_in.wdata[1:0]};
      end
   end

   // wake source flags; set on wake, cleared on next sleep entry
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         io_flag <= 1'b0;
         rtc_flag <= 1'b0;
         detect <= 4'h0;
      end else if (wake_now) begin
         io_flag <= io_wake;
         rtc_flag <= rtc_wake || pulse_wake;
         detect <= {pulse_wake, pin_hit};
      end else if (sleep_req) begin
         io_flag <= 1'b0;
         rtc_flag <= 1'b0;
         detect <= 4'h0;
      end
   end

   // system reset pulse for one cycle after a reset-wake
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reset_pulse <= 1'b0;
      end else begin
         reset_pulse <= do_reset;
      end
   end

   // register read, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (bus_in.rd) begin
         if (bus_in.addr == swc_pkg::ADDR_SYSTEM_STATE) begin
            rdata_out <= {4'h0, io_flag, rtc_flag, 1'b0, pg_sync_b};
         end else if (bus_in.addr == swc_pkg::ADDR_IO_WAKE_DETECT) begin
            rdata_out <= {4'h0, detect};
         end else if (bus_in.addr == swc_pkg::ADDR_WAKE_CONTROL) begin
            rdata_out <= wctl;
         end else if (bus_in.addr == swc_pkg::ADDR_CLOCK_SLEEP_CONTROL) begin
            rdata_out <= {csc[7:1], mcu_src};
         end else begin
            rdata_out <= 8'h00;
         end
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // outputs; asleep stops the mcu, rtc and regulator stay on
   assign power_state_out = state;
   assign mcu_clock_enable_out = !asleep;
   assign mcu_clock_pll_out = mcu_src && !asleep;
   // pll may stay on through sleep unless osc force dropped it
   assign pll_enable_out = csc[swc_pkg::CS_PLL_LOCK] || csc[swc_pkg::CS_MCU_SEL];
   assign meter_clock_enable_out = !csc[swc_pkg::CS_METER_GATE];
   assign lcd_clock_enable_out = !csc[swc_pkg::CS_LCD_GATE];
   assign rtc_enable_out = 1'b1;
   assign regulator_enable_out = 1'b1;
   assign system_reset_out = reset_pulse;

   // a reset-wake always lands in osc state next cycle
   property p_reset_wake;
      @(posedge mclk_in) disable iff (!rst_n_in)
      do_reset |=> state == swc_pkg::SWC_OSC && system_reset_out;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset wake missed");

   property p_deep_ignores;
      @(posedge mclk_in) disable iff (!rst_n_in)
      state == swc_pkg::SWC_DEEP && !io_wake && !events_in.power_recover |=>
         state == swc_pkg::SWC_DEEP;
   endproperty
   a_deep_ignores: assert property (p_deep_ignores) else $error("deep woke wrongly");

   property p_resume_clear;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wake_now && !do_reset |=> csc[6:5] == 2'h0 && csc[2:1] == 2'h0 && !system_reset_out;
   endproperty
   a_resume_clear: assert property (p_resume_clear) else $error("resume not clean");

   property p_no_reset_mode;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wake_now && wctl[0] |=> !system_reset_out;
   endproperty
   a_no_reset_mode: assert property (p_no_reset_mode) else $error("reset in resume");

   property p_port0_gate;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !wctl[1] |-> pin_hit[2:1] == 2'h0;
   endproperty
   a_port0_gate: assert property (p_port0_gate) else $error("port0 woke ungated");

   property p_io_flag;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wake_now && io_wake |=> io_flag && detect[2:0] != 3'h0;
   endproperty
   a_io_flag: assert property (p_io_flag) else $error("io flag missing");

   property p_pulse_flag;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wake_now && pulse_wake |=> rtc_flag && detect[3];
   endproperty
   a_pulse_flag: assert property (p_pulse_flag) else $error("pulse flag missing");

   property p_deep_code;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !asleep && sleep_req && code == 2'h2 && !bus_in.wdata[5] |=> state == swc_pkg::SWC_DEEP;
   endproperty
   a_deep_code: assert property (p_deep_code) else $error("deep code ignored");

   property p_sleep_stops;
      @(posedge mclk_in) disable iff (!rst_n_in)
      asleep |-> !mcu_clock_enable_out && rtc_enable_out;
   endproperty
   a_sleep_stops: assert property (p_sleep_stops) else $error("mcu clock in sleep");

   // osc force while power is not good lands in sleep with the pll stopped
   property p_quick_sleep;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wr_csc && bus_in.wdata[swc_pkg::CS_OSC_FORCE] && !pg_sync_b && !asleep |=>
         state == swc_pkg::SWC_SLEEP && !pll_enable_out;
   endproperty
   a_quick_sleep: assert property (p_quick_sleep) else $error("quick sleep wrong");

   property p_pg_refuse;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wr_csc && pg_sync_b && !asleep |=> !asleep;
   endproperty
   a_pg_refuse: assert property (p_pg_refuse) else $error("slept with power good");

   property p_src_read;
      @(posedge mclk_in) disable iff (!rst_n_in)
      bus_in.rd && bus_in.addr == swc_pkg::ADDR_CLOCK_SLEEP_CONTROL |=>
         rdata_out[swc_pkg::CS_MCU_SEL] == $past(mcu_src);
   endproperty
   a_src_read: assert property (p_src_read) else $error("source readback wrong");

   property p_rtc_wakes;
      @(posedge mclk_in) disable iff (!rst_n_in)
      state == swc_pkg::SWC_SLEEP && events_in.rtc |=> !asleep;
   endproperty
   a_rtc_wakes: assert property (p_rtc_wakes) else $error("rtc did not wake");

   property p_osc_runs;
      @(posedge mclk_in) disable iff (!rst_n_in)
      state == swc_pkg::SWC_OSC |-> mcu_clock_enable_out && regulator_enable_out;
   endproperty
   a_osc_runs: assert property (p_osc_runs) else $error("osc state not running");

   property p_rtc_flag;
      @(posedge mclk_in) disable iff (!rst_n_in)
      wake_now && rtc_wake && !pulse_wake |=> rtc_flag && !detect[3];
   endproperty
   a_rtc_flag: assert property (p_rtc_flag) else $error("rtc flag wrong");
endmodule

// file: shared/swc_pkg.sv
// package for the sleep and wake controller: register map, fields, states
// assumes a byte-wide register port with one-cycle strobes
package swc_pkg;
   // register indices (byte addresses on the plain port)
   localparam logic [7:0] ADDR_SYSTEM_STATE = 8'hA1;
   localparam logic [7:0] ADDR_IO_WAKE_DETECT = 8'hAF;
   localparam logic [7:0] ADDR_WAKE_CONTROL = 8'hC9;
   localparam logic [7:0] ADDR_CLOCK_SLEEP_CONTROL = 8'h80;
   // system_state fields
   localparam int SS_POWER_GOOD = 0;
   localparam int SS_RTC_WAKE = 2;
   localparam int SS_IO_WAKE = 3;
   // io_wake_detect fields
   localparam int WD_PIN_A = 0;
   localparam int WD_PIN_B = 1;
   localparam int WD_PIN_C = 2;
   localparam int WD_PULSE = 3;
   // wake_control fields
   localparam int WC_NO_RESET = 0;
   localparam int WC_PORT0 = 1;
   // clock_sleep_control fields
   localparam int CS_MCU_SEL = 0;
   localparam int CS_SLEEP_LOW = 1;
   localparam int CS_SLEEP_HIGH = 2;
   localparam int CS_LCD_GATE = 3;
   localparam int CS_METER_GATE = 4;
   localparam int CS_OSC_FORCE = 5;
   localparam int CS_PLL_LOCK = 6;
   localparam int CS_METER_SEL = 7;
   // reset values
   localparam logic [7:0] RST_WAKE_CONTROL = 8'h00;
   localparam logic [7:0] RST_CLOCK_SLEEP_CONTROL = 8'h00;
   // wake pin stability: more than 4 osc cycles on each level
   localparam int WAKE_STABLE_CYCLES = 4;
   localparam int NUM_WAKE_PINS = 4;
   // sleep codes
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_DEEP = 2'h2;

   typedef enum logic [1:0] {SWC_OSC, SWC_WORK, SWC_SLEEP, SWC_DEEP} swc_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } swc_bus_req_t;

   typedef struct packed {
      logic rtc;
      logic pulse;
      logic power_recover;
   } swc_events_t;
endpackage

// file: src/swc_pin_filter.sv
// one wake pin: two-flop synchroniser, stability counter, edge detect
// assumes the pin is asynchronous to mclk_in
`timescale 1ns/100ps
module swc_pin_filter #(
   parameter int STABLE = 4
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   output logic edge_out
);
   logic sync_a;
   logic sync_b;
   logic stable_lvl;
   logic [7:0] run;
   logic [1:0] fill;

   // first flop feeds only the second
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= pin_in;
         sync_b <= sync_a;
      end
   end

   // a new level counts only after it outlasts STABLE cycles
   // the resting level is adopted while the synchroniser fills, so a pin
   // that idles high gives no false edge after reset
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run <= 8'h00;
         stable_lvl <= 1'b0;
         edge_out <= 1'b0;
         fill <= 2'h0;
      end else begin
         edge_out <= 1'b0;
         if (fill != 2'h3) begin
            fill <= fill + 2'h1;
            stable_lvl <= sync_b;
            run <= 8'h00;
         end else if (sync_b == stable_lvl) begin
            run <= 8'h00;
         end else if (run >= 8'(STABLE)) begin
            stable_lvl <= sync_b;
            run <= 8'h00;
            edge_out <= 1'b1;
         end else begin
            run <= run + 8'h01;
         end
      end
   end
endmodule

// file: verification/swc_testbench.sv
// self-checking bench for the sleep and wake controller
// assumes swc_pkg and swc_top are compiled first; the bench drives every port
`timescale 1ns/100ps
module testbench;
   logic mclk_in;
   logic rst_n_in;
   swc_pkg::swc_bus_req_t bus;
   swc_pkg::swc_events_t ev;
   logic [7:0] rdata_out;
   logic [3:0] pins;
   logic [3:0] pin_en;
   logic power_good;
   logic pll_locked;
   logic [1:0] power_state_out;
   logic mcu_clock_enable_out;
   logic mcu_clock_pll_out;
   logic pll_enable_out;
   logic meter_clock_enable_out;
   logic lcd_clock_enable_out;
   logic rtc_enable_out;
   logic regulator_enable_out;
   logic system_reset_out;
   int n_errors;
   int total_checks;
   logic [7:0] exp_q[$];
   logic rd_seen;
   logic [7:0] rnd;
   int i;
   localparam logic [7:0] CS = swc_pkg::ADDR_CLOCK_SLEEP_CONTROL;
   localparam logic [7:0] WC = swc_pkg::ADDR_WAKE_CONTROL;
   localparam logic [7:0] SS = swc_pkg::ADDR_SYSTEM_STATE;
   localparam logic [7:0] WD = swc_pkg::ADDR_IO_WAKE_DETECT;
   localparam logic [1:0] ST_SLEEP = swc_pkg::SWC_SLEEP;
   localparam logic [1:0] ST_DEEP = swc_pkg::SWC_DEEP;

   swc_top #(.STABLE(4)) i_dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata_out),
      .wake_pin_in(pins), .wake_pin_enable_in(pin_en), .events_in(ev),
      .power_good_in(power_good), .pll_locked_in(pll_locked),
      .power_state_out(power_state_out), .mcu_clock_enable_out(mcu_clock_enable_out),
      .mcu_clock_pll_out(mcu_clock_pll_out), .pll_enable_out(pll_enable_out),
      .meter_clock_enable_out(meter_clock_enable_out),
      .lcd_clock_enable_out(lcd_clock_enable_out), .rtc_enable_out(rtc_enable_out),
      .regulator_enable_out(regulator_enable_out), .system_reset_out(system_reset_out));

   // 200 MHz oscillator clock
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // read data stands only in the cycle after the strobe, so look there
   always @(posedge mclk_in) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("Error at %0t: read data with no expectation", $time);
         end else begin
            check(rdata_out, exp_q.pop_front());
         end
      end
      rd_seen <= bus.rd;
   end

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge mclk_in);
      bus.wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      bus.addr <= a;
      bus.rd <= 1'b1;
      exp_q.push_back(exp);
      @(posedge mclk_in);
      bus.rd <= 1'b0;
   endtask

   // one-cycle event: bit 2 rtc, bit 1 energy pulse, bit 0 power recovery
   task automatic pulse(input logic [2:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= 3'h0;
   endtask

   // hold 0 leaves the pin at its new level; otherwise a short glitch
   task automatic tog(input int idx, input int hold);
      @(posedge mclk_in);
      pins[idx] <= ~pins[idx];
      if (hold > 0) begin
         repeat (hold) @(posedge mclk_in);
         pins[idx] <= ~pins[idx];
      end
   endtask

   task automatic enter(input logic [7:0] d, input logic [1:0] st);
      reg_wr(CS, d);
      @(negedge mclk_in);
      check(power_state_out, st);
      check(mcu_clock_enable_out, 1'b0);
      check(rtc_enable_out, 1'b1);
   endtask

   // long enough for the pin filter to have fired if it were going to
   task automatic quiet(input logic [1:0] st);
      repeat (30) @(negedge mclk_in);
      check(power_state_out, st);
   endtask

   task automatic wake(input logic rst_exp);
      logic seen;
      seen = 1'b0;
      for (int k = 0; k < 40 && power_state_out !== 2'h0; k++) begin
         @(negedge mclk_in);
         seen = seen | system_reset_out;
      end
      repeat (2) begin
         @(negedge mclk_in);
         seen = seen | system_reset_out;
      end
      check(power_state_out, 2'h0);
      check(seen, rst_exp);
   endtask

   // bounded by far more cycles than the sequence needs
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_errors++;
      end_of_test();
   end

   // main sequence
   initial begin
      bus = '0;
      ev = '0;
      pins = 4'h0;
      pin_en = 4'hF;
      power_good = 1'b0;
      pll_locked = 1'b1;
      rst_n_in = 1'b0;
      rd_seen = 1'b0;
      n_errors = 0;
      total_checks = 0;
      rnd = 8'($urandom(40));
      repeat (8) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(negedge mclk_in);
      check(power_state_out, 2'h0);
      check(mcu_clock_enable_out, 1'b1);
      check(regulator_enable_out, 1'b1);
      check(mcu_clock_pll_out, 1'b0);
      reg_rd(CS, 8'h00);
      reg_rd(WC, 8'h00);
      reg_rd(8'h55, 8'h00);
      reg_rd(SS, 8'h00);
      reg_wr(WC, rnd);
      reg_rd(WC, rnd & 8'h03);
      reg_wr(WC, 8'h00);
      // sleep request refused while power is good
      @(posedge mclk_in);
      power_good <= 1'b1;
      repeat (4) @(posedge mclk_in);
      reg_wr(CS, 8'h04);
      @(negedge mclk_in);
      check(power_state_out, 2'h0);
      check(mcu_clock_enable_out, 1'b1);
      reg_rd(SS, 8'h01);
      reg_wr(CS, 8'h00);
      @(posedge mclk_in);
      power_good <= 1'b0;
      repeat (4) @(posedge mclk_in);
      // every sleep code, woken by power recovery with reset
      for (i = 1; i < 4; i++) begin
         enter(8'(i << 1), (i == 2) ? ST_DEEP : ST_SLEEP);
         check(meter_clock_enable_out, 1'b1);
         check(lcd_clock_enable_out, 1'b1);
         pulse(3'h1);
         wake(1'b1);
      end
      // deep sleep ignores rtc, pulse, disabled pins and glitches
      pin_en <= 4'hE;
      enter(8'h04, ST_DEEP);
      pulse(3'h4);
      pulse(3'h2);
      tog(0, 0);
      tog(1, 2);
      quiet(ST_DEEP);
      tog(1, 0);
      wake(1'b1);
      reg_rd(SS, 8'h08);
      reg_rd(WD, 8'h01);
      pin_en <= 4'hF;
      // sleep woken by rtc, then by the energy pulse
      enter(8'h02, ST_SLEEP);
      pulse(3'h4);
      wake(1'b1);
      reg_rd(SS, 8'h04);
      reg_rd(WD, 8'h00);
      enter(8'h06, ST_SLEEP);
      pulse(3'h2);
      wake(1'b1);
      reg_rd(SS, 8'h04);
      reg_rd(WD, 8'h08);
      // port0 pins need their enable
      enter(8'h02, ST_SLEEP);
      tog(2, 0);
      quiet(ST_SLEEP);
      pulse(3'h1);
      wake(1'b1);
      reg_wr(WC, 8'h02);
      enter(8'h02, ST_SLEEP);
      tog(3, 0);
      wake(1'b1);
      reg_rd(SS, 8'h08);
      reg_rd(WD, 8'h04);
      // resume without reset clears only the lock, force and code bits
      reg_wr(WC, 8'h03);
      enter(8'h52, ST_SLEEP);
      pulse(3'h4);
      wake(1'b0);
      reg_rd(CS, 8'h10);
      reg_rd(WC, 8'h03);
      check(meter_clock_enable_out, 1'b0);
      // quick method reaches sleep with the pll off
      reg_wr(WC, 8'h00);
      enter(8'h60, ST_SLEEP);
      check(pll_enable_out, 1'b0);
      tog(1, 0);
      wake(1'b1);
      reg_rd(CS, 8'h00);
      // pll as mcu source, then the lcd clock gated while it is selected
      reg_wr(CS, 8'h01);
      @(negedge mclk_in);
      check(mcu_clock_pll_out, 1'b1);
      check(pll_enable_out, 1'b1);
      reg_rd(CS, 8'h01);
      reg_wr(CS, 8'h09);
      @(negedge mclk_in);
      check(power_state_out, 2'h1);
      check(lcd_clock_enable_out, 1'b0);
      // pll drops lock: the source in use falls back to osc
      @(posedge mclk_in);
      pll_locked <= 1'b0;
      @(negedge mclk_in);
      check(mcu_clock_pll_out, 1'b0);
      reg_rd(CS, 8'h08);
      @(posedge mclk_in);
      pll_locked <= 1'b1;
      reg_wr(CS, 8'h05);
      @(negedge mclk_in);
      check(mcu_clock_enable_out, 1'b1);
      // quick method straight from the pll source
      enter(8'h21, ST_SLEEP);
      check(pll_enable_out, 1'b0);
      check(mcu_clock_pll_out, 1'b0);
      pulse(3'h1);
      wake(1'b1);
      repeat (3) @(posedge mclk_in);
      end_of_test();
   end
endmodule
